// ### src/pcix_status_pkg.sv
// constants and carriers for the secondary capability and bridge split status registers
package pcix_status_pkg;

	// register byte offsets on the apb window
	localparam logic [11:0] CAP_STAT_OFS  = 12'h080;
	localparam logic [11:0] BRDG_STAT_OFS = 12'h084;
	localparam logic [11:0] IRQ_STAT_OFS  = 12'h090;
	localparam logic [11:0] IRQ_MASK_OFS  = 12'h094;

	// shared field positions of both status words
	localparam int unsigned REQ_DELAY_BIT   = 21;
	localparam int unsigned OVERRUN_BIT     = 20;
	localparam int unsigned UNEXPECTED_BIT  = 19;
	localparam int unsigned DISCARDED_BIT   = 18;
	localparam int unsigned FAST_CLOCK_BIT  = 17;
	localparam int unsigned WIDE_BUS_BIT    = 16;
	localparam int unsigned NEXT_LINK_LSB   = 8;
	localparam int unsigned CAPABILITY_IDENTIFIER_LSB      = 0;
	localparam int unsigned BUS_NUM_LSB     = 8;
	localparam int unsigned CAPTURED_DEVICE_NUMBER_LSB     = 3;
	localparam int unsigned CAPTURED_FUNCTION_NUMBER_LSB    = 0;
	localparam int unsigned FLAG_STRB_LANE  = 2;
	localparam int unsigned IRQ_STRB_LANE   = 0;

	// hardwired field values
	localparam logic       FAST_CLOCK_VAL   = 1'b1;
	localparam logic       WIDE_BUS_VAL     = 1'b1;
	localparam logic [7:0] NEXT_LINK_VAL    = 8'hA0;
	localparam logic [7:0] CAPABILITY_IDENTIFIER_VAL       = 8'h07;
	localparam logic [4:0] OWN_CAPTURED_DEVICE_NUMBER      = 5'h00;
	localparam logic [2:0] OWN_CAPTURED_FUNCTION_NUMBER     = 3'h0;
	localparam logic [4:0] DEV_RESET        = 5'h00;
	localparam logic [2:0] FUNC_RESET       = 3'h0;

	// interrupt status and mask layout
	localparam int unsigned IRQ_W           = 3;
	localparam int unsigned IRQ_SPLIT_UNEXP = 0;
	localparam int unsigned IRQ_DISCARD     = 1;
	localparam int unsigned IRQ_UP_UNEXP    = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET  = 3'h0;

	// unexpected split completion seen on the secondary bus
	typedef struct packed {
		logic       unexpected;
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] func;
	} split_cpl_t;

	// end of a split completion started by the bridge
	typedef struct packed {
		logic done;
		logic masterAbort;
		logic targetAbort;
	} cpl_end_t;

	// type 0 configuration write arriving from upstream
	typedef struct packed {
		logic       valid;
		logic [4:0] dev;
		logic [2:0] func;
	} cfg_wr_t;

endpackage

// ### src/pcix_capability_status_regs.sv
// split status flags, hardwired capability fields and apb register slave
//
// Functional notes
// RL1: flag bit 19 on unexpected split completion addressed to own secondary requester ID.
// RL2: aborted bridge split completion is discarded and sets capability-status bit 18.
// RL3: capability-status bit 17 always reads 1; writes ignored.
// RL4: capability-status bit 16 reports 64-bit secondary bus, reads 1.
// RL5: capability-status bits 15:8 read fixed link value A0.
// RL6: capability-status bits 7:0 read fixed identifier 07.
// RL7: bridge-status bit 21 is unsupported and always reads 0.
// RL8: bridge-status bit 20 is unsupported and always reads 0.
// RL9: bridge-status bit 19 set by unexpected upstream completion, cleared writing one.
// RL10: bridge-status bit 18 always reads 0, writes ignored.
// RL11: every type 0 config write captures its device number into bits 7:3.
// RL12: completer ID built from bus, device, function; function resets to zero.
// RL13: reserved bits read zero; writing zero leaves sticky flags untouched.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module pcix_capability_status_regs
	import pcix_status_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// bridge core events
	input  wire split_cpl_t  splitCpl,
	input  wire cpl_end_t    cplEnd,
	input  wire logic        upstreamUnexpected,
	input  wire cfg_wr_t     cfgWr,
	// bus numbers held elsewhere in config space
	input  wire logic [7:0]  primaryBusNum,
	input  wire logic [7:0]  secondaryBusNum,
	// results
	output logic             cplDiscard,
	output logic [15:0]      completerId,
	output logic             irq
);

	// state
	logic             pready_r;
	logic             pready_nxt;
	logic [31:0]      prdata_r;
	logic [31:0]      prdata_nxt;
	logic             pslverr_r;
	logic             pslverr_nxt;
	logic             splitUnexp_r;
	logic             splitUnexp_nxt;
	logic             discarded_r;
	logic             discarded_nxt;
	logic             upUnexp_r;
	logic             upUnexp_nxt;
	logic [4:0]       devNum_r;
	logic [4:0]       devNum_nxt;
	logic [2:0]       funcNum_r;
	logic [2:0]       funcNum_nxt;
	logic [IRQ_W-1:0] irqStat_r;
	logic [IRQ_W-1:0] irqStat_nxt;
	logic [IRQ_W-1:0] irqMask_r;
	logic [IRQ_W-1:0] irqMask_nxt;
	logic             irq_r;
	logic             irq_nxt;
	logic             cplDiscard_r;
	logic             cplDiscard_nxt;
	logic [15:0]      completerId_r;
	logic [15:0]      completerId_nxt;

	// decoded events and bus strobes
	logic             splitHit;
	logic             discardHit;
	logic             accessPhase;
	logic             wrDone;
	logic             capClr;
	logic             discClr;
	logic             brdgClr;
	logic [IRQ_W-1:0] irqClr;
	logic [IRQ_W-1:0] irqEvents;
	logic [31:0]      capWord;
	logic [31:0]      brdgWord;
	logic [31:0]      readMux;
	logic             mapped;

	// event qualification; requester ID must be our own secondary identity
	always_comb
	begin
		splitHit   = splitCpl.unexpected && (splitCpl.bus == secondaryBusNum)
			&& (splitCpl.dev == OWN_CAPTURED_DEVICE_NUMBER) && (splitCpl.func == OWN_CAPTURED_FUNCTION_NUMBER); // RL1
		discardHit = cplEnd.done && (cplEnd.masterAbort || cplEnd.targetAbort); // RL2
		irqEvents  = '0;
		irqEvents[IRQ_SPLIT_UNEXP] = splitHit;
		irqEvents[IRQ_DISCARD]     = discardHit;
		irqEvents[IRQ_UP_UNEXP]    = upstreamUnexpected;
	end

	// bus strobes; a write lands only on the edge where pready is seen high
	always_comb
	begin
		accessPhase = psel && penable && !pready_r;
		wrDone      = psel && penable && pready_r && pwrite;
		capClr      = wrDone && (paddr == CAP_STAT_OFS) && pstrb[FLAG_STRB_LANE]
			&& pwdata[UNEXPECTED_BIT];
		discClr     = wrDone && (paddr == CAP_STAT_OFS) && pstrb[FLAG_STRB_LANE]
			&& pwdata[DISCARDED_BIT]; // RL2
		brdgClr     = wrDone && (paddr == BRDG_STAT_OFS) && pstrb[FLAG_STRB_LANE]
			&& pwdata[UNEXPECTED_BIT];
		irqClr      = (wrDone && (paddr == IRQ_STAT_OFS) && pstrb[IRQ_STRB_LANE])
			? pwdata[IRQ_W-1:0] : '0;
	end

	// read words; every bit not named below stays zero
	always_comb
	begin
		capWord = '0; // RL13
		capWord[UNEXPECTED_BIT] = splitUnexp_r; // RL1
		capWord[DISCARDED_BIT]  = discarded_r; // RL2
		capWord[FAST_CLOCK_BIT] = FAST_CLOCK_VAL; // RL3
		capWord[WIDE_BUS_BIT]   = WIDE_BUS_VAL; // RL4
		capWord[NEXT_LINK_LSB +: 8] = NEXT_LINK_VAL; // RL5
		capWord[CAPABILITY_IDENTIFIER_LSB +: 8]    = CAPABILITY_IDENTIFIER_VAL; // RL6
		brdgWord = '0; // RL7 RL8 RL10 RL13
		brdgWord[UNEXPECTED_BIT]   = upUnexp_r; // RL9
		brdgWord[BUS_NUM_LSB +: 8] = primaryBusNum;
		brdgWord[CAPTURED_DEVICE_NUMBER_LSB +: 5] = devNum_r; // RL11
		brdgWord[CAPTURED_FUNCTION_NUMBER_LSB +: 3] = funcNum_r; // RL12
		mapped  = 1'b1;
		readMux = '0;
		unique case (paddr)
			CAP_STAT_OFS:  readMux = capWord;
			BRDG_STAT_OFS: readMux = brdgWord;
			IRQ_STAT_OFS:  readMux[IRQ_W-1:0] = irqStat_r;
			IRQ_MASK_OFS:  readMux[IRQ_W-1:0] = irqMask_r;
			default:       mapped = 1'b0;
		endcase
	end

	// apb answer: one wait state so every output leaves a flip-flop
	always_comb
	begin
		pready_nxt  = accessPhase;
		prdata_nxt  = (accessPhase && !pwrite) ? readMux : '0;
		pslverr_nxt = accessPhase && !mapped;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r  <= pready_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// sticky flags; a set in the clearing cycle wins over the clear
	always_comb
	begin
		splitUnexp_nxt = splitHit || (splitUnexp_r && !capClr); // RL1 RL13
		discarded_nxt  = discardHit || (discarded_r && !discClr); // RL2 RL13
		upUnexp_nxt    = upstreamUnexpected || (upUnexp_r && !brdgClr); // RL9 RL13
		irqStat_nxt    = irqEvents | (irqStat_r & ~irqClr);
		irqMask_nxt    = (wrDone && (paddr == IRQ_MASK_OFS) && pstrb[IRQ_STRB_LANE])
			? pwdata[IRQ_W-1:0] : irqMask_r;
		irq_nxt        = |(irqStat_nxt & irqMask_nxt);
		cplDiscard_nxt = discardHit; // RL2
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			splitUnexp_r <= 1'b0;
			discarded_r  <= 1'b0;
			upUnexp_r    <= 1'b0;
			irqStat_r    <= IRQ_RESET;
			irqMask_r    <= IRQ_RESET;
			irq_r        <= 1'b0;
			cplDiscard_r <= 1'b0;
		end
		else
		begin
			splitUnexp_r <= splitUnexp_nxt;
			discarded_r  <= discarded_nxt;
			upUnexp_r    <= upUnexp_nxt;
			irqStat_r    <= irqStat_nxt;
			irqMask_r    <= irqMask_nxt;
			irq_r        <= irq_nxt;
			cplDiscard_r <= cplDiscard_nxt;
		end
	end

	// identity capture; any type 0 write updates it, whatever register it targets
	always_comb
	begin
		devNum_nxt  = cfgWr.valid ? cfgWr.dev : devNum_r; // RL11
		funcNum_nxt = cfgWr.valid ? cfgWr.func : funcNum_r; // RL12
		completerId_nxt = {primaryBusNum, devNum_nxt, funcNum_nxt}; // RL12
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			devNum_r      <= DEV_RESET;
			funcNum_r     <= FUNC_RESET;
			completerId_r <= '0;
		end
		else
		begin
			devNum_r      <= devNum_nxt;
			funcNum_r     <= funcNum_nxt;
			completerId_r <= completerId_nxt;
		end
	end

	// outputs straight from flip-flops
	assign pready      = pready_r;
	assign prdata      = prdata_r;
	assign pslverr     = pslverr_r;
	assign irq         = irq_r;
	assign cplDiscard  = cplDiscard_r;
	assign completerId = completerId_r;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_splitSet;
		splitHit |=> splitUnexp_r ##1 (splitUnexp_r || $past(capClr));
	endproperty
	a_splitSet: assert property (p_splitSet) else $error("split flag not set"); // RL1

	property p_discard;
		discardHit |=> (discarded_r && cplDiscard_r);
	endproperty
	a_discard: assert property (p_discard) else $error("discard not flagged"); // RL2

	property p_fastClock;
		(accessPhase && !pwrite && paddr == CAP_STAT_OFS) |=> (pready && prdata[17]);
	endproperty
	a_fastClock: assert property (p_fastClock) else $error("fast clock bit wrong"); // RL3

	property p_wideBus;
		(accessPhase && !pwrite && paddr == CAP_STAT_OFS) |=> prdata[16];
	endproperty
	a_wideBus: assert property (p_wideBus) else $error("wide bus bit wrong"); // RL4

	property p_nextLink;
		(accessPhase && !pwrite && paddr == CAP_STAT_OFS) |=> (prdata[15:8] == 8'hA0);
	endproperty
	a_nextLink: assert property (p_nextLink) else $error("next link wrong"); // RL5

	property p_capId;
		(accessPhase && !pwrite && paddr == CAP_STAT_OFS) |=> (prdata[7:0] == 8'h07);
	endproperty
	a_capId: assert property (p_capId) else $error("capability id wrong"); // RL6

	property p_reqDelay;
		(accessPhase && !pwrite && paddr == BRDG_STAT_OFS) |=> !prdata[21];
	endproperty
	a_reqDelay: assert property (p_reqDelay) else $error("bit 21 not zero"); // RL7

	property p_overrun;
		(accessPhase && !pwrite && paddr == BRDG_STAT_OFS) |=> !prdata[20];
	endproperty
	a_overrun: assert property (p_overrun) else $error("bit 20 not zero"); // RL8

	property p_upSet;
		upstreamUnexpected |=> upUnexp_r;
	endproperty
	a_upSet: assert property (p_upSet) else $error("upstream flag not set"); // RL9

	property p_bit18;
		(accessPhase && !pwrite && paddr == BRDG_STAT_OFS) |=> (!prdata[18] && !prdata[31]);
	endproperty
	a_bit18: assert property (p_bit18) else $error("bit 18 not zero"); // RL10

	property p_devCapture;
		cfgWr.valid |=> (devNum_r == $past(cfgWr.dev));
	endproperty
	a_devCapture: assert property (p_devCapture) else $error("device not captured"); // RL11

	property p_completer;
		cfgWr.valid |=> (completerId[7:0] == {$past(cfgWr.dev), $past(cfgWr.func)});
	endproperty
	a_completer: assert property (p_completer) else $error("completer id wrong"); // RL12

	property p_flagHold;
		(upUnexp_r && !brdgClr) |=> upUnexp_r;
	endproperty
	a_flagHold: assert property (p_flagHold) else $error("flag lost without clear"); // RL13

	property p_irq;
		(irqStat_r & irqMask_r) != '0 |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// ### sim/testbench.sv
// self-checking bench for the split status register slave
`timescale 1ns/1ps

module testbench;
	import pcix_status_pkg::*;

	logic        mclk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	split_cpl_t  splitCpl;
	cpl_end_t    cplEnd;
	logic        upstreamUnexpected;
	cfg_wr_t     cfgWr;
	logic [7:0]  primaryBusNum;
	logic [7:0]  secondaryBusNum;
	logic        cplDiscard;
	logic [15:0] completerId;
	logic        irq;
	int          n_errors;
	int          num_checks;

	pcix_capability_status_regs i_pcix_capability_status_regs (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.splitCpl(splitCpl), .cplEnd(cplEnd), .upstreamUnexpected(upstreamUnexpected),
		.cfgWr(cfgWr), .primaryBusNum(primaryBusNum), .secondaryBusNum(secondaryBusNum),
		.cplDiscard(cplDiscard), .completerId(completerId), .irq(irq)
	);

	// free-running core clock, 8 ns
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is sampled high, however long
	// that takes, so only the watchdog can end a hung wait
	task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
		input logic [3:0] sb, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= adr;
		pwdata  <= wd;
		pstrb   <= sb;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		// one wait state: pready is seen on the second access edge
		chk("accessEdges", 32'h2, n);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] adr, input logic [31:0] d, input logic [3:0] sb);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, adr, d, sb, rd, e);
	endtask

	task automatic rdchk(input string what, input logic [11:0] adr, input logic [31:0] exp);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, adr, 32'h0, 4'hF, rd, e);
		chk(what, exp, rd);
	endtask

	// let a pulse be taken and the flag settle before reading
	task automatic settle();
		repeat (2) @(posedge mclk);
	endtask

	task automatic t_reset();
		rdchk("capStat", CAP_STAT_OFS, 32'h0003A007);
		rdchk("brdgStat", BRDG_STAT_OFS, 32'h00005A00);
		rdchk("irqMask", IRQ_MASK_OFS, 32'h0);
		chk("completerId", 32'h5A00, {16'h0, completerId});
		$display("test reset done");
	endtask

	task automatic t_split_unexp();
		wr(IRQ_MASK_OFS, 32'h7, 4'h1);
		@(posedge mclk);
		splitCpl <= '{1'b1, 8'h3C, 5'h01, 3'h0};
		@(posedge mclk);
		splitCpl <= '{1'b0, 8'h3C, 5'h00, 3'h0};
		settle();
		rdchk("capOther", CAP_STAT_OFS, 32'h0003A007);
		chk("irqIdle", 32'h0, {31'h0, irq});
		@(posedge mclk);
		splitCpl <= '{1'b1, 8'h3C, 5'h00, 3'h0};
		@(posedge mclk);
		splitCpl.unexpected <= 1'b0;
		settle();
		chk("irqSet", 32'h1, {31'h0, irq});
		rdchk("capOwn", CAP_STAT_OFS, 32'h000BA007);
		wr(CAP_STAT_OFS, 32'h0, 4'hF);
		rdchk("capZeroWr", CAP_STAT_OFS, 32'h000BA007);
		wr(CAP_STAT_OFS, 32'h00080000, 4'hB);
		rdchk("capNoLane", CAP_STAT_OFS, 32'h000BA007);
		wr(CAP_STAT_OFS, 32'h00080000, 4'hF);
		rdchk("capClear", CAP_STAT_OFS, 32'h0003A007);
		rdchk("irqStat", IRQ_STAT_OFS, 32'h1);
		wr(IRQ_STAT_OFS, 32'h1, 4'h1);
		settle();
		chk("irqClr", 32'h0, {31'h0, irq});
		$display("test split unexpected done");
	endtask

	task automatic t_discard();
		logic seen;
		for (int k = 0; k < 3; k++)
		begin
			seen = 1'b0;
			@(posedge mclk);
			cplEnd <= '{1'b1, k == 1, k == 2};
			@(posedge mclk);
			cplEnd <= '{1'b0, 1'b0, 1'b0};
			repeat (3)
			begin
				@(posedge mclk);
				seen = seen | cplDiscard;
			end
			chk("cplDiscard", {31'h0, k != 0}, {31'h0, seen});
			rdchk("capDisc", CAP_STAT_OFS, (k != 0) ? 32'h0007A007 : 32'h0003A007);
			wr(CAP_STAT_OFS, 32'h00040000, 4'hF);
		end
		rdchk("capDiscClr", CAP_STAT_OFS, 32'h0003A007);
		$display("test discard done");
	endtask

	task automatic t_upstream();
		@(posedge mclk);
		upstreamUnexpected <= 1'b1;
		@(posedge mclk);
		upstreamUnexpected <= 1'b0;
		settle();
		rdchk("brdgUnexp", BRDG_STAT_OFS, 32'h00085A00);
		rdchk("irqStat", IRQ_STAT_OFS, 32'h6);
		wr(BRDG_STAT_OFS, 32'hFFFFFFFF, 4'hF);
		rdchk("brdgClr", BRDG_STAT_OFS, 32'h00005A00);
		wr(CAP_STAT_OFS, 32'hFFFFFFFF, 4'hF);
		rdchk("capRo", CAP_STAT_OFS, 32'h0003A007);
		wr(IRQ_STAT_OFS, 32'h7, 4'h1);
		settle();
		chk("irqClr", 32'h0, {31'h0, irq});
		$display("test upstream done");
	endtask

	task automatic t_capture();
		logic [31:0] rd;
		logic        e;
		@(posedge mclk);
		cfgWr <= '{1'b1, 5'h15, 3'h5};
		@(posedge mclk);
		cfgWr <= '{1'b0, 5'h00, 3'h0};
		settle();
		rdchk("brdgDev", BRDG_STAT_OFS, 32'h00005AAD);
		chk("completerId", 32'h5AAD, {16'h0, completerId});
		apb(1'b0, 12'h0A0, 32'h0, 4'hF, rd, e);
		chk("unmappedErr", 32'h1, {31'h0, e});
		chk("unmappedData", 32'h0, rd);
		$display("test capture done");
	endtask

	// watchdog against a hung handshake
	initial
	begin
		#200000;
		n_errors++;
		give_verdict();
	end

	initial
	begin
		n_errors = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, upstreamUnexpected} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		splitCpl = '0;
		cplEnd = '0;
		cfgWr = '0;
		primaryBusNum = 8'h5A;
		secondaryBusNum = 8'h3C;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_split_unexp();
		t_discard();
		t_upstream();
		t_capture();
		give_verdict();
	end
endmodule
